// >>> tdh_pkg.sv
/*
  Shared constants and types for the display host port: I/O codes, command bit positions,
  control codes, page geometry and timing counts.
  Assumes a single 40 MHz clock.
*/
`default_nettype none
package tdh_pkg;
  localparam logic [7:0] IO_SER_DATA = 8'hE4;
  localparam logic [7:0] IO_MEM = 8'hE5;
  localparam logic [7:0] IO_KEY_RAW = 8'hE6;
  localparam logic [7:0] IO_LINE = 8'hE7;
  localparam logic [7:0] IO_REQ_WORD = 8'hF6;
  localparam logic [7:0] IO_SER_FLAGS = 8'hF7;
  localparam int CMD_BIT_LINE = 0;
  localparam int CMD_BIT_TRANS = 1;
  localparam int CMD_BIT_CLEAR = 2;
  localparam int CMD_BIT_TXEN = 3;
  localparam int ATTR_BIT = 7;
  localparam logic [7:0] CC_ERASE_LINE = 8'h04;
  localparam logic [7:0] CC_LF = 8'h0A;
  localparam logic [7:0] CC_CR = 8'h0D;
  localparam logic [7:0] CC_UNDERLINE = 8'h0E;
  localparam logic [7:0] CC_NORMAL = 8'h0F;
  localparam logic [7:0] CC_CURSOR_LOAD = 8'h10;
  localparam logic [7:0] CC_ERASE_PAGE = 8'h19;
  localparam logic [7:0] CC_HOME = 8'h1D;
  localparam logic [7:0] CC_FIRST_PRINT = 8'h20;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam int COLS = 80;
  localparam logic [6:0] LAST_COL = 7'h4F;
  localparam logic [4:0] LAST_LINE = 5'h18;
  localparam logic [10:0] PAGE_LAST_ADDR = 11'h7CF;
  localparam int CLK_PERIOD_PS = 25000;
  localparam longint RTC_PERIOD_PS = 64'd19985795400;
  localparam int RTC_CYC = int'(RTC_PERIOD_PS / CLK_PERIOD_PS);
  localparam int PAGE_ERASE_MAX_NS = 1400000;
  localparam int PAGE_ERASE_MAX_CYC = PAGE_ERASE_MAX_NS / (CLK_PERIOD_PS / 1000);
  localparam int LINE_ERASE_MAX_NS = 100000;
  localparam int LINE_ERASE_MAX_CYC = LINE_ERASE_MAX_NS / (CLK_PERIOD_PS / 1000);
  typedef enum logic [1:0] {
    CMD_IDLE = 2'h0,
    CMD_LINE_NEXT = 2'h1,
    CMD_COL_NEXT = 2'h3,
    CMD_ERASING = 2'h2
  } tdh_cmd_t;
  typedef enum logic [2:0] {
    ATTR_NORMAL = 3'h0,
    ATTR_LOW = 3'h1,
    ATTR_BLINK = 3'h2,
    ATTR_INVERT = 3'h3,
    ATTR_UNDERLINE = 3'h4,
    ATTR_INVISIBLE = 3'h5
  } tdh_attr_t;
endpackage
`default_nettype wire

// >>> tdh_host_port.sv
/*
  Processor-facing parallel I/O port of the display terminal logic: serial data and flags,
  keyboard, line handshake, character memory with cursor, erase engine, timer tick.
  Assumes one I/O access per cycle, memory read data valid for mem_addr_out in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tdh_host_port
  import tdh_pkg::*;
#(
  parameter int RTC_CYCLES = RTC_CYC,
  parameter int PAGE_ERASE_LIMIT = PAGE_ERASE_MAX_CYC
)(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  input wire logic [7:0] ser_rx_data_in,
  input wire logic rx_byte_available_in,
  input wire logic tx_buffer_empty_in,
  input wire logic rx_parity_error_in,
  input wire logic rx_overrun_in,
  input wire logic rx_framing_error_in,
  output logic [7:0] ser_tx_data_out,
  output logic ser_tx_load_out,
  output logic ser_rx_ack_out,
  input wire logic [6:0] key_code_in,
  input wire logic key_byte_available_in,
  output logic key_ack_out,
  input wire logic connect_set_to_line_n_in,
  input wire logic set_ready_n_in,
  input wire logic request_send_n_in,
  input wire logic ready_for_sending_n_in,
  input wire logic carrier_detect_n_in,
  input wire logic line_ring_indicator_n_in,
  output logic host_line_control_out,
  output logic host_transmit_control_out,
  output logic host_clear_out,
  output logic tx_empty_irq_switch_out,
  input wire logic mem_busy_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [10:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_we_out,
  output logic scroll_up_out,
  output logic [2:0] attr_mode_out,
  output logic rtc_irq_out,
  output logic svc_irq_out
);
  typedef struct packed {
    tdh_cmd_t cmd;
    logic [4:0] line;
    logic [6:0] col;
    logic underline;
    logic wbusy;
    logic mbusy;
    logic txen;
    logic [2:0] cmd_bits;
    logic [10:0] er_addr;
    logic [10:0] er_last;
    tdh_attr_t attr;
    logic [19:0] rtc_cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic [10:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic scroll;
    logic [7:0] tx_data;
    logic tx_load;
    logic rx_ack;
    logic key_ack;
    logic rtc_irq;
    logic svc_irq;
  } tdh_state_t;

  localparam logic [19:0] RTC_LAST = 20'(RTC_CYCLES - 1);

  logic [1:0] rst_sync_q;
  logic rst_n;
  tdh_state_t st_q;
  tdh_state_t st_d;
  logic [12:0] adv;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [10:0] addr_of(input logic [4:0] ln, input logic [6:0] cl);
    addr_of = 11'(int'(ln) * COLS + int'(cl));
  endfunction

  // Returns {scroll, line, col}; roll selects scrolling on writes or home wrap on reads.
  function automatic logic [12:0] advance(input logic [4:0] ln, input logic [6:0] cl,
                                          input logic roll);
    if (cl != LAST_COL)
      advance = {1'b0, ln, 7'(cl + 7'h01)};
    else if (ln != LAST_LINE)
      advance = {1'b0, 5'(ln + 5'h01), 7'h00};
    else if (roll)
      advance = {1'b1, ln, 7'h00};
    else
      advance = 13'h0000;
  endfunction

  function automatic tdh_attr_t attr_of(input logic [2:0] b);
    unique case (b)
      3'h2: attr_of = ATTR_LOW;
      3'h3: attr_of = ATTR_BLINK;
      3'h4: attr_of = ATTR_INVERT;
      3'h5: attr_of = ATTR_UNDERLINE;
      3'h6: attr_of = ATTR_INVISIBLE;
      default: attr_of = ATTR_NORMAL;
    endcase
  endfunction

  function automatic logic [7:0] req_of(input logic mb, input logic wb, input logic en);
    req_of = {2'h0, !line_ring_indicator_n_in, mb, wb, key_byte_available_in,
              rx_byte_available_in, tx_buffer_empty_in & en};
  endfunction

  always_comb
  begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.mem_we = 1'b0;
    st_d.scroll = 1'b0;
    st_d.tx_load = 1'b0;
    st_d.rx_ack = 1'b0;
    st_d.key_ack = 1'b0;
    st_d.rtc_irq = 1'b0;
    adv = 13'h0000;
    if (st_q.rtc_cnt >= RTC_LAST)
    begin
      st_d.rtc_cnt = 20'h00000;
      st_d.rtc_irq = 1'b1;
    end
    else
      st_d.rtc_cnt = st_q.rtc_cnt + 20'h00001;
    if (st_q.cmd == CMD_ERASING && !mem_busy_in)
    begin
      st_d.mem_we = 1'b1;
      st_d.mem_addr = st_q.er_addr;
      st_d.mem_wdata = SPACE_CODE;
      if (st_q.er_addr == st_q.er_last)
        st_d.cmd = CMD_IDLE;
      else
        st_d.er_addr = st_q.er_addr + 11'h001;
    end
    if (io_rd_in)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 8'h00;
      case (io_addr_in)
        IO_SER_DATA:
        begin
          st_d.rdata = ser_rx_data_in;
          st_d.rx_ack = 1'b1;
        end
        IO_MEM:
          if (mem_busy_in || st_q.cmd == CMD_ERASING)
            st_d.mbusy = 1'b1;
          else
          begin
            st_d.rdata = mem_rdata_in;
            adv = advance(st_q.line, st_q.col, 1'b0);
            st_d.line = adv[11:7];
            st_d.col = adv[6:0];
          end
        IO_KEY_RAW:
        begin
          st_d.rdata = {1'b0, key_code_in};
          st_d.key_ack = 1'b1;
        end
        IO_LINE:
          st_d.rdata = {2'h0, line_ring_indicator_n_in, carrier_detect_n_in,
                        ready_for_sending_n_in, request_send_n_in, set_ready_n_in,
                        connect_set_to_line_n_in};
        IO_REQ_WORD:
        begin
          st_d.rdata = req_of(st_q.mbusy, st_q.wbusy, st_q.txen);
          st_d.wbusy = 1'b0;
          st_d.mbusy = 1'b0;
        end
        IO_SER_FLAGS:
          st_d.rdata = {2'h0, rx_framing_error_in, rx_overrun_in, rx_parity_error_in,
                        st_q.txen, rx_byte_available_in, tx_buffer_empty_in};
        default:
          st_d.rvalid = 1'b0;
      endcase
    end
    else if (io_wr_in)
    begin
      case (io_addr_in)
        IO_SER_DATA:
          if (!tx_buffer_empty_in)
            st_d.wbusy = 1'b1;
          else
          begin
            st_d.tx_data = io_wdata_in;
            st_d.tx_load = 1'b1;
          end
        IO_LINE:
        begin
          st_d.cmd_bits = io_wdata_in[CMD_BIT_CLEAR:CMD_BIT_LINE];
          st_d.txen = io_wdata_in[CMD_BIT_TXEN];
        end
        IO_MEM, IO_KEY_RAW:
          if (st_q.cmd == CMD_ERASING)
            st_d.wbusy = 1'b1;
          else if (io_addr_in == IO_MEM && st_q.cmd == CMD_LINE_NEXT)
          begin
            st_d.line = io_wdata_in[4:0];
            st_d.cmd = CMD_COL_NEXT;
          end
          else if (io_addr_in == IO_MEM && st_q.cmd == CMD_COL_NEXT)
          begin
            st_d.col = io_wdata_in[6:0];
            st_d.cmd = CMD_IDLE;
          end
          else if (io_addr_in == IO_MEM && io_wdata_in < CC_FIRST_PRINT)
          begin
            case (io_wdata_in)
              CC_CURSOR_LOAD:
                st_d.cmd = CMD_LINE_NEXT;
              CC_ERASE_LINE:
              begin
                st_d.er_addr = addr_of(st_q.line, 7'h00);
                st_d.er_last = addr_of(st_q.line, LAST_COL);
                st_d.col = 7'h00;
                st_d.cmd = CMD_ERASING;
              end
              CC_ERASE_PAGE:
              begin
                st_d.er_addr = 11'h000;
                st_d.er_last = PAGE_LAST_ADDR;
                st_d.line = 5'h00;
                st_d.col = 7'h00;
                st_d.attr = ATTR_NORMAL;
                st_d.cmd = CMD_ERASING;
              end
              CC_UNDERLINE:
                st_d.underline = 1'b1;
              CC_NORMAL:
                st_d.underline = 1'b0;
              CC_CR:
                st_d.col = 7'h00;
              CC_LF:
                if (st_q.line == LAST_LINE)
                  st_d.scroll = 1'b1;
                else
                  st_d.line = st_q.line + 5'h01;
              CC_HOME:
              begin
                st_d.line = 5'h00;
                st_d.col = 7'h00;
              end
              default:
                st_d.cmd = st_q.cmd;
            endcase
          end
          else if (mem_busy_in)
            st_d.wbusy = 1'b1;
          else
          begin
            st_d.mem_we = 1'b1;
            st_d.mem_addr = addr_of(st_q.line, st_q.col);
            st_d.mem_wdata = {io_wdata_in[ATTR_BIT] | st_q.underline, io_wdata_in[6:0]};
            if (st_d.mem_wdata[ATTR_BIT])
              st_d.attr = attr_of(io_wdata_in[6:4]);
            adv = advance(st_q.line, st_q.col, 1'b1);
            st_d.scroll = adv[12];
            st_d.line = adv[11:7];
            st_d.col = adv[6:0];
          end
        default:
          st_d.cmd = st_q.cmd;
      endcase
    end
    // The address idles on the cursor so a read sees the cursor cell with no extra cycle.
    if (!st_d.mem_we)
      st_d.mem_addr = addr_of(st_d.line, st_d.col);
    st_d.svc_irq = |req_of(st_d.mbusy, st_d.wbusy, st_d.txen);
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign io_rdata_out = st_q.rdata;
  assign io_rvalid_out = st_q.rvalid;
  assign ser_tx_data_out = st_q.tx_data;
  assign ser_tx_load_out = st_q.tx_load;
  assign ser_rx_ack_out = st_q.rx_ack;
  assign key_ack_out = st_q.key_ack;
  assign host_line_control_out = st_q.cmd_bits[CMD_BIT_LINE];
  assign host_transmit_control_out = st_q.cmd_bits[CMD_BIT_TRANS];
  assign host_clear_out = st_q.cmd_bits[CMD_BIT_CLEAR];
  assign tx_empty_irq_switch_out = st_q.txen;
  assign mem_addr_out = st_q.mem_addr;
  assign mem_wdata_out = st_q.mem_wdata;
  assign mem_we_out = st_q.mem_we;
  assign scroll_up_out = st_q.scroll;
  assign attr_mode_out = st_q.attr;
  assign rtc_irq_out = st_q.rtc_irq;
  assign svc_irq_out = st_q.svc_irq;

  // Helper timing of the erase engine, read only by the checks below.
  int er_cyc_q;
  logic er_page_q;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      er_cyc_q <= 0;
      er_page_q <= 1'b0;
    end
    else
    begin
      er_cyc_q <= (st_q.cmd == CMD_ERASING) ? er_cyc_q + 1 : 0;
      if (st_q.cmd != CMD_ERASING)
        er_page_q <= (st_d.er_last == PAGE_LAST_ADDR);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  a_rtc_tick: assert property (rtc_irq_out |-> st_q.rtc_cnt == 20'h00000 ##1 !rtc_irq_out)
    else $error("timer tick not aligned to counter wrap");
  a_tx_refused: assert property (io_wr_in && io_addr_in == IO_SER_DATA && !tx_buffer_empty_in
    |=> st_q.wbusy && !ser_tx_load_out) else $error("refused serial write not flagged");
  a_mem_busy_rd: assert property (io_rd_in && io_addr_in == IO_MEM && mem_busy_in
    |=> st_q.mbusy && $stable(st_q.col) && $stable(st_q.line))
    else $error("busy memory read moved cursor or missed flag");
  a_key_map: assert property (io_rd_in && io_addr_in == IO_KEY_RAW
    |=> io_rvalid_out && io_rdata_out == {1'b0, $past(key_code_in)})
    else $error("keyboard byte wrong");
  a_flag_byte: assert property (io_rd_in && io_addr_in == IO_SER_FLAGS
    |=> io_rdata_out[7:6] == 2'h0 && io_rdata_out[0] == $past(tx_buffer_empty_in)
        && io_rdata_out[2] == $past(st_q.txen)) else $error("serial flag byte wrong");
  a_req_word: assert property (io_rd_in && io_addr_in == IO_REQ_WORD
    |=> io_rdata_out[4:3] == $past({st_q.mbusy, st_q.wbusy}) && io_rdata_out[7:6] == 2'h0)
    else $error("request word wrong");
  a_line_stat: assert property (io_rd_in && io_addr_in == IO_LINE
    |=> io_rdata_out[4] == $past(carrier_detect_n_in)
        && io_rdata_out[5] == $past(line_ring_indicator_n_in)) else $error("line status wrong");
  a_line_cmd: assert property (io_wr_in && io_addr_in == IO_LINE
    |=> host_transmit_control_out == $past(io_wdata_in[1])
        && tx_empty_irq_switch_out == $past(io_wdata_in[3])) else $error("line command lost");
  a_raw_store: assert property (io_wr_in && io_addr_in == IO_KEY_RAW && st_q.cmd == CMD_IDLE
    && !mem_busy_in |=> mem_we_out && mem_wdata_out[6:0] == $past(io_wdata_in[6:0])
    && mem_addr_out == addr_of($past(st_q.line), $past(st_q.col))) else $error("raw store wrong");
  a_ctrl_nostore: assert property (io_wr_in && io_addr_in == IO_MEM && st_q.cmd == CMD_IDLE
    && io_wdata_in < CC_FIRST_PRINT |=> !mem_we_out) else $error("control code was stored");
  a_wr_scroll: assert property (io_wr_in && io_addr_in == IO_KEY_RAW && st_q.cmd == CMD_IDLE
    && !mem_busy_in && st_q.line == LAST_LINE && st_q.col == LAST_COL
    |=> scroll_up_out && st_q.col == 7'h00 && st_q.line == LAST_LINE) else $error("no scroll");
  a_rd_wrap: assert property (io_rd_in && io_addr_in == IO_MEM && st_q.cmd == CMD_IDLE
    && !mem_busy_in && st_q.line == LAST_LINE && st_q.col == LAST_COL
    |=> !scroll_up_out && st_q.col == 7'h00 && st_q.line == 5'h00) else $error("bad read wrap");
  a_load_seq: assert property (io_wr_in && io_addr_in == IO_MEM && st_q.cmd == CMD_IDLE
    && io_wdata_in == CC_CURSOR_LOAD |=> st_q.cmd == CMD_LINE_NEXT) else $error("no load");
  a_uline_force: assert property (mem_we_out && $past(st_q.cmd) != CMD_ERASING
    && $past(st_q.underline) |-> mem_wdata_out[ATTR_BIT]) else $error("underline not forced");
  a_page_time: assert property (er_page_q |-> er_cyc_q < PAGE_ERASE_LIMIT)
    else $error("page erase too slow");
  a_line_time: assert property (!er_page_q |-> er_cyc_q < LINE_ERASE_MAX_CYC)
    else $error("line erase too slow");
  a_svc_level: assert property (st_q.wbusy || st_q.mbusy
    || !$past(line_ring_indicator_n_in) || $past(key_byte_available_in) |-> svc_irq_out)
    else $error("service request missing");

  c_page_erase: cover property (st_q.cmd == CMD_ERASING ##1 st_q.cmd == CMD_IDLE);
  c_scroll: cover property (scroll_up_out);
  c_cursor_load: cover property (st_q.cmd == CMD_LINE_NEXT ##[1:20] st_q.cmd == CMD_COL_NEXT);
  c_rtc: cover property (rtc_irq_out);
endmodule // tdh_host_port
`default_nettype wire

// >>> tdh_mem_model.sv
/*
  Character memory seen from the far side of the host port: 2048 bytes, write on the clock.
  Assumes the read data follows the address with no delay, as the port expects.
*/
`timescale 1ns/1ps
`default_nettype none
module tdh_mem_model
(
  input wire logic clk_in,
  input wire logic [10:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic we_in,
  output logic [7:0] rdata_out
);
  logic [7:0] ram [0:2047];
  // Cells start at FF so that a missed write never looks like a stored space.
  initial
  begin
    for (int i = 0; i < 2048; i++) ram[i] = 8'hFF;
  end
  always @(posedge clk_in)
  begin
    if (we_in) ram[addr_in] <= wdata_in;
  end
  assign rdata_out = ram[addr_in];
endmodule // tdh_mem_model
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the display host port: I/O read and write tasks, then sequences.
  Assumes the memory model answers at once; the timer count is shortened to 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tdh_pkg::*;
  localparam int RTC_N = 16;
  logic clk_in, nrst_in, wr, rd, rxa, txe, pe, ovr, fe, kav, busy, rvalid, tx_ld, rx_ack;
  logic conn_n, sready_n, req_send_n, ready_send_n, carrier_n, ring_n, key_ack, mem_we;
  logic line_c, trans_c, clr_c, txen_c, scroll, rtc, svc;
  logic [7:0] addr, wd, ser_rx, rdata, mem_rd, tx_d, mem_wd, d;
  logic [6:0] key;
  logic [10:0] mem_addr;
  logic [2:0] attr;
  int n_mismatch, checks, n_scroll, i, k;
  tdh_host_port #(.RTC_CYCLES(RTC_N)) u_tdh_host_port (.clk_in(clk_in), .nrst_in(nrst_in),
    .io_addr_in(addr), .io_wdata_in(wd), .io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdata),
    .io_rvalid_out(rvalid), .ser_rx_data_in(ser_rx), .rx_byte_available_in(rxa),
    .tx_buffer_empty_in(txe), .rx_parity_error_in(pe), .rx_overrun_in(ovr),
    .rx_framing_error_in(fe), .ser_tx_data_out(tx_d), .ser_tx_load_out(tx_ld),
    .ser_rx_ack_out(rx_ack), .key_code_in(key), .key_byte_available_in(kav),
    .key_ack_out(key_ack), .connect_set_to_line_n_in(conn_n), .set_ready_n_in(sready_n),
    .request_send_n_in(req_send_n), .ready_for_sending_n_in(ready_send_n),
    .carrier_detect_n_in(carrier_n), .line_ring_indicator_n_in(ring_n),
    .host_line_control_out(line_c), .host_transmit_control_out(trans_c),
    .host_clear_out(clr_c), .tx_empty_irq_switch_out(txen_c), .mem_busy_in(busy),
    .mem_rdata_in(mem_rd), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wd),
    .mem_we_out(mem_we), .scroll_up_out(scroll), .attr_mode_out(attr), .rtc_irq_out(rtc),
    .svc_irq_out(svc));
  tdh_mem_model u_tdh_mem_model (.clk_in(clk_in), .addr_in(mem_addr), .wdata_in(mem_wd),
    .we_in(mem_we), .rdata_out(mem_rd));
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (scroll === 1'b1) n_scroll++;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic io_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic io_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
    chk("rvalid", rvalid, 1);
  endtask
  task automatic cur_load(input logic [7:0] ln, input logic [7:0] col);
    io_wr(IO_MEM, CC_CURSOR_LOAD);
    io_wr(IO_MEM, ln);
    io_wr(IO_MEM, col);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {wr, rd, rxa, txe, pe, ovr, fe, kav, busy, nrst_in} = '0;
    {conn_n, sready_n, req_send_n, ready_send_n, carrier_n, ring_n} = 6'h3F;
    {addr, wd, ser_rx, key} = '0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    idle(3);
    chk("addr_rst", mem_addr, 11'h000);
    chk("svc_rst", svc, 0);
    {ring_n, carrier_n, ready_send_n, req_send_n, sready_n, conn_n} <= 6'h15;
    io_rd(IO_LINE, d);
    chk("line_status", d, 8'h15);
    io_wr(IO_LINE, 8'hFF);
    chk("line_cmd", {txen_c, clr_c, trans_c, line_c}, 4'hF);
    io_wr(IO_LINE, 8'h08);
    chk("line_cmd2", {txen_c, clr_c, trans_c, line_c}, 4'h8);
    io_wr(IO_REQ_WORD, 8'hFF);
    chk("wr_ignored", {txen_c, clr_c, trans_c, line_c}, 4'h8);
    {txe, rxa, pe, ovr, fe, kav} <= 6'h3F;
    io_rd(IO_SER_FLAGS, d);
    chk("ser_flags", d, 8'h3F);
    chk("svc_on", svc, 1);
    io_rd(IO_REQ_WORD, d);
    chk("req_word", d, 8'h27);
    $display("test status done");
    io_wr(IO_SER_DATA, 8'hC3);
    chk("tx_data", tx_d, 8'hC3);
    chk("tx_load", tx_ld, 1'b1);
    ser_rx <= 8'h9A;
    io_rd(IO_SER_DATA, d);
    chk("rx_data", d, 8'h9A);
    chk("rx_ack", rx_ack, 1);
    key <= 7'h5A;
    io_rd(IO_KEY_RAW, d);
    chk("key", d, 8'h5A);
    chk("key_ack", key_ack, 1);
    txe <= 1'b0;
    io_wr(IO_SER_DATA, 8'h11);
    chk("tx_kept", tx_d, 8'hC3);
    chk("tx_noload", tx_ld, 1'b0);
    io_rd(IO_REQ_WORD, d);
    chk("wbusy", d, 8'h2E);
    io_rd(IO_REQ_WORD, d);
    chk("wbusy_clr", d, 8'h26);
    {ring_n, kav, rxa} <= 3'h4;
    idle(3);
    chk("svc_off", svc, 0);
    $display("test serial done");
    cur_load(8'h00, 8'h4E);
    io_wr(IO_KEY_RAW, 8'h41);
    io_wr(IO_MEM, 8'h42);
    io_wr(IO_MEM, 8'h43);
    io_wr(IO_MEM, 8'h01);
    idle(2);
    chk("ram78", u_tdh_mem_model.ram[78], 8'h41);
    chk("ram79", u_tdh_mem_model.ram[79], 8'h42);
    chk("ram80", u_tdh_mem_model.ram[80], 8'h43);
    chk("ram81", u_tdh_mem_model.ram[81], 8'hFF);
    chk("cursor81", mem_addr, 11'd81);
    busy <= 1'b1;
    io_rd(IO_MEM, d);
    chk("busy_rd", d, 8'h00);
    busy <= 1'b0;
    idle(1);
    chk("busy_cur", mem_addr, 11'd81);
    io_rd(IO_REQ_WORD, d);
    chk("mbusy", d, 8'h10);
    io_rd(IO_MEM, d);
    chk("rd81", d, 8'hFF);
    chk("cursor82", mem_addr, 11'd82);
    cur_load(8'h18, 8'h4F);
    idle(1);
    io_rd(IO_MEM, d);
    chk("rd_wrap", mem_addr, 11'd0);
    cur_load(8'h18, 8'h4F);
    io_wr(IO_KEY_RAW, 8'h20);
    idle(2);
    chk("scroll", n_scroll, 1);
    chk("scroll_cur", mem_addr, 11'd1920);
    $display("test cursor done");
    io_wr(IO_MEM, CC_UNDERLINE);
    io_wr(IO_MEM, 8'h31);
    io_wr(IO_MEM, CC_NORMAL);
    io_wr(IO_MEM, 8'h31);
    idle(2);
    chk("ul_on", u_tdh_mem_model.ram[1920], 8'hB1);
    chk("ul_off", u_tdh_mem_model.ram[1921], 8'h31);
    chk("attr_ul", attr, 3'h2);
    for (k = 0; k < 8; k++)
    begin
      io_wr(IO_KEY_RAW, 8'h80 | 8'(k << 4));
      idle(1);
      chk("attr", attr, (k < 2 || k == 7) ? 3'h0 : 3'(k - 1));
    end
    $display("test attribute done");
    io_wr(IO_MEM, CC_ERASE_LINE);
    idle(LINE_ERASE_MAX_CYC);
    k = 0;
    for (i = 1920; i < 2000; i++) k += (u_tdh_mem_model.ram[i] !== 8'h20);
    chk("line_clr", k, 0);
    chk("line_cur", mem_addr, 11'd1920);
    io_wr(IO_MEM, CC_ERASE_PAGE);
    io_wr(IO_KEY_RAW, 8'h55);
    idle(PAGE_ERASE_MAX_CYC);
    k = 0;
    for (i = 0; i < 2000; i++) k += (u_tdh_mem_model.ram[i] !== 8'h20);
    chk("page_clr", k, 0);
    chk("page_home", mem_addr, 11'd0);
    chk("page_attr", attr, 3'h0);
    io_rd(IO_REQ_WORD, d);
    chk("erase_wbusy", d, 8'h08);
    $display("test erase done");
    for (i = 0; i < 40 && rtc !== 1'b1; i++) idle(1);
    idle(1);
    for (k = 1; k < 40 && rtc !== 1'b1; k++) idle(1);
    chk("rtc_period", k, RTC_N);
    $display("test timer done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
